// >>> hdl/tcel_top.sv
// Six-channel timer mode logic with APB register access
//
// Contract
// - Capture edge chosen by select bits
// - Compare action chosen by select bits
// - Select bits zero return pin to port
// - Reset clears both select bits
// - Buffered set mode drives high on match
// - Overflow toggles pin when enabled
// - Overflow toggle ignored in capture mode
// - Reset clears overflow toggle enable
// - Overflow wins over simultaneous compare
// - Capture codes: rise, fall, both edges
// - Compare codes: none, toggle, low, high
// - Preset level is inverse of mode bit
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcel_top #(
    parameter int NUM_CH = tcel_pkg::NUM_CH,
    parameter int ADDR_W = tcel_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Timer events
    input  wire logic              counter_ovf,
    input  wire logic [NUM_CH-1:0] compare_match,
    // Channel pins
    input  wire logic [NUM_CH-1:0] timer_channel_pin_in,
    output logic      [NUM_CH-1:0] timer_channel_pin_out,
    output logic      [NUM_CH-1:0] timer_channel_pin_oe,
    // General-purpose port side
    input  wire logic [NUM_CH-1:0] port_pin_out,
    input  wire logic [NUM_CH-1:0] port_pin_oe,
    // Capture strobes
    output logic      [NUM_CH-1:0] capture_stb
);
    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] STAT_A = ADDR_W'(tcel_pkg::STATUS_OFS);
    localparam logic [ADDR_W-1:0] BASE_A = ADDR_W'(tcel_pkg::CTRL_BASE);

    logic [tcel_pkg::CTRL_W-1:0] ctrl_q [NUM_CH];
    logic [31:0]                 prdata_q;
    logic [31:0]                 rd_word;
    logic [ADDR_W-1:0]           rel_a;
    logic [2:0]                  idx;
    logic                        hit_ctrl;
    logic                        hit_stat;
    logic                        access;
    logic                        wr_en;
    logic [NUM_CH-1:0]           flag_v;
    logic [NUM_CH-1:0]           lvl_v;
    logic [NUM_CH-1:0]           own_v;

    assign rel_a    = paddr - BASE_A;
    assign idx      = rel_a[4:2];
    assign hit_ctrl = (rel_a[1:0] == 2'h0) && (paddr >= BASE_A) &&
                      (rel_a < ADDR_W'(4 * NUM_CH));
    assign hit_stat = (paddr == STAT_A);
    assign access   = psel && penable;
    assign wr_en    = access && pwrite;

    // Zero wait states: every transfer finishes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = access && !(hit_ctrl || hit_stat);

    // ------------------------------------------------------------------
    // Channel control registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_q[i] <= tcel_pkg::CTRL_RST;
            end
        end else if (wr_en && hit_ctrl) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (idx == 3'(i)) begin
                    ctrl_q[i] <= pwdata[tcel_pkg::CTRL_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_stat) begin
            rd_word[tcel_pkg::ST_FLAG_LSB +: NUM_CH] = flag_v;
            rd_word[tcel_pkg::ST_PIN_LSB  +: NUM_CH] = timer_channel_pin_in;
            rd_word[tcel_pkg::ST_OWN_LSB  +: NUM_CH] = own_v;
        end else if (hit_ctrl) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (idx == 3'(i)) begin
                    rd_word[tcel_pkg::CTRL_W-1:0] = ctrl_q[i];
                end
            end
        end
    end

    // Captured in the setup cycle so the data is a flop output in access
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_word;
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Channels and pin muxing
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        tcel_chan_if cif ();

        assign cif.els[0]   = ctrl_q[g][tcel_pkg::ELS_LO_BIT];
        assign cif.els[1]   = ctrl_q[g][tcel_pkg::ELS_HI_BIT];
        assign cif.tov      = ctrl_q[g][tcel_pkg::TOV_BIT];
        assign cif.ms_a     = ctrl_q[g][tcel_pkg::MSA_BIT];
        assign cif.ms_b     = ctrl_q[g][tcel_pkg::MSB_BIT];
        // Write one to a status flag bit clears it
        assign cif.flag_clr = wr_en && hit_stat &&
                              pwdata[tcel_pkg::ST_FLAG_LSB + g];

        tcel_chan u_chan (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .ovf     (counter_ovf),
            .match   (compare_match[g]),
            .pin_in  (timer_channel_pin_in[g]),
            .cif     (cif)
        );

        assign flag_v[g] = cif.flag;
        assign lvl_v[g]  = cif.out_lvl;
        assign own_v[g]  = cif.owns;
        // Port keeps the pin whenever the channel lets go of it
        assign timer_channel_pin_out[g] = cif.owns ? cif.out_lvl
                                                   : port_pin_out[g];
        assign timer_channel_pin_oe[g]  = cif.owns ? cif.drives
                                                   : port_pin_oe[g];
        assign capture_stb[g] = cif.cap;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_port_handover: assert property (
        (ctrl_q[0][1:0] == tcel_pkg::ELS_OFF) |->
        (timer_channel_pin_out[0] == port_pin_out[0]) &&
        (timer_channel_pin_oe[0] == port_pin_oe[0]))
        else $error("port does not own idle pin");
    a_oc_drives_pin: assert property (
        (ctrl_q[0][1:0] != tcel_pkg::ELS_OFF) && ctrl_q[0][4:3] != 2'h0 |->
        timer_channel_pin_oe[0] && timer_channel_pin_out[0] == lvl_v[0])
        else $error("compare channel not driving");
    a_ic_releases: assert property (
        (ctrl_q[0][1:0] != tcel_pkg::ELS_OFF) && ctrl_q[0][4:3] == 2'h0 |->
        !timer_channel_pin_oe[0])
        else $error("capture channel drives pin");
    a_ctrl_write: assert property (
        wr_en && hit_ctrl && idx == 3'h0 |=>
        ctrl_q[0] == $past(pwdata[tcel_pkg::CTRL_W-1:0]))
        else $error("control write lost");
    a_read_data: assert property (
        psel && !penable && !pwrite ##1 access |->
        prdata == $past(rd_word))
        else $error("read data not held");
    a_flag_clear: assert property (
        wr_en && hit_stat && pwdata[0] && !compare_match[0] &&
        !capture_stb[0] && ctrl_q[0][4:3] != 2'h0 |=> !flag_v[0])
        else $error("flag clear ignored");

    c_apb_write: cover property (wr_en && hit_ctrl);
    c_apb_error: cover property (pslverr);
    c_handover:  cover property (own_v[0] ##1 !own_v[0]);
endmodule : tcel_top
`default_nettype wire

// >>> pkg/tcel_pkg.sv
// Shared constants for the timer channel edge/level/toggle block
`default_nettype none
package tcel_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int         NUM_CH      = 6;
    localparam int         ADDR_W      = 8;
    localparam int         CTRL_W      = 5;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_BASE   = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h18;
    // ------------------------------------------------------------------
    // Channel control fields
    // ------------------------------------------------------------------
    localparam int         ELS_LO_BIT  = 0;
    localparam int         ELS_HI_BIT  = 1;
    localparam int         TOV_BIT     = 2;
    localparam int         MSA_BIT     = 3;
    localparam int         MSB_BIT     = 4;
    localparam logic [4:0] CTRL_RST    = 5'h00;
    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int         ST_FLAG_LSB = 0;
    localparam int         ST_PIN_LSB  = 8;
    localparam int         ST_OWN_LSB  = 16;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       OUT_RST     = 1'b1;
    localparam logic [1:0] ELS_OFF     = 2'h0;
endpackage : tcel_pkg
`default_nettype wire

// >>> pkg/tcel_chan_if.sv
// Configuration and status carrier between top and one channel
`timescale 1ns/1ps
`default_nettype none
interface tcel_chan_if;
    logic [1:0] els;
    logic       tov;
    logic       ms_a;
    logic       ms_b;
    logic       flag_clr;
    logic       flag;
    logic       out_lvl;
    logic       owns;
    logic       drives;
    logic       cap;

    modport ctl  (output els, tov, ms_a, ms_b, flag_clr,
                  input  flag, out_lvl, owns, drives, cap);
    modport chan (input  els, tov, ms_a, ms_b, flag_clr,
                  output flag, out_lvl, owns, drives, cap);
endinterface : tcel_chan_if
`default_nettype wire

// >>> hdl/tcel_chan.sv
// One capture/compare channel: edge sensing, compare action, overflow toggle
`timescale 1ns/1ps
`default_nettype none
module tcel_chan (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // Timer events
    input  wire logic ovf,
    input  wire logic match,
    // Pin level
    input  wire logic pin_in,
    // Configuration and status
    tcel_chan_if.chan cif
);
    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic       pres;
    logic       is_ic;
    logic       is_oc;
    logic       oc_cfg;
    logic       prev_q;
    logic       rise;
    logic       fall;
    logic       edge_hit;
    logic       ovf_act;
    logic       out_q;
    logic       flag_q;
    logic       cap_q;

    assign pres   = (cif.els == tcel_pkg::ELS_OFF);
    assign oc_cfg = cif.ms_a || cif.ms_b;
    assign is_ic  = !pres && !oc_cfg;
    assign is_oc  = !pres && oc_cfg;

    // ------------------------------------------------------------------
    // Edge sensing
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin_in;
        end
    end

    assign rise     = pin_in && !prev_q;
    assign fall     = !pin_in && prev_q;
    assign edge_hit = is_ic && ((cif.els[0] && rise) ||
                                (cif.els[1] && fall));

    // ------------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------------
    // Overflow toggle is gated by output-compare mode and the tov enable bit
    assign ovf_act = is_oc && cif.tov && ovf;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= tcel_pkg::OUT_RST;
        end else if (pres) begin
            out_q <= !cif.ms_a;
        end else if (ovf_act) begin
            out_q <= !out_q;
        end else if (is_oc && match) begin
            if (cif.els == 2'h1) begin
                out_q <= !out_q;
            end else if (cif.els == 2'h2) begin
                out_q <= 1'b0;
            end else begin
                out_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Event flag and capture strobe
    // ------------------------------------------------------------------
    // Set beats a simultaneous software clear so no event is lost
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else if (edge_hit || (oc_cfg && match)) begin
            flag_q <= 1'b1;
        end else if (cif.flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_q <= 1'b0;
        end else begin
            cap_q <= edge_hit;
        end
    end

    assign cif.flag    = flag_q;
    assign cif.out_lvl = out_q;
    assign cif.owns    = !pres;
    assign cif.drives  = is_oc;
    assign cif.cap     = cap_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_preset_level: assert property (pres |=> out_q == !$past(cif.ms_a))
        else $error("preset level wrong");
    a_ovf_toggle: assert property (is_oc && cif.tov && ovf
                                   |=> out_q != $past(out_q))
        else $error("overflow toggle missed");
    a_ovf_hold: assert property (is_oc && !cif.tov && ovf && !match
                                 |=> $stable(out_q))
        else $error("pin moved on overflow");
    a_set_match: assert property (is_oc && cif.els == 2'h3 && match &&
                                  !(cif.tov && ovf) |=> out_q)
        else $error("set on compare missed");
    a_clear_match: assert property (is_oc && cif.els == 2'h2 && match &&
                                    !(cif.tov && ovf) |=> !out_q)
        else $error("clear on compare missed");
    a_ic_no_toggle: assert property (is_ic |=> $stable(out_q))
        else $error("capture channel output moved");
    a_rise_capture: assert property (is_ic && cif.els == 2'h1 && pin_in
                                     && !prev_q |=> cap_q && flag_q)
        else $error("rising edge not captured");
    a_fall_only: assert property (is_ic && cif.els == 2'h2 && rise
                                  |=> !cap_q)
        else $error("rising edge captured in fall mode");

    c_capture: cover property (is_ic && cif.els == 2'h3 && fall ##1 cap_q);
    c_ovf_win: cover property (is_oc && cif.tov && ovf && match);
endmodule : tcel_chan
`default_nettype wire

// >>> test/tcel_pin_model.sv
// Pin-side model: resolves shared channel pins from all drivers
`timescale 1ns/1ps
`default_nettype none
module tcel_pin_model #(
    parameter int N = 6
) (
    // Drive from the block
    input  wire logic [N-1:0] dut_out,
    input  wire logic [N-1:0] dut_oe,
    // Drive from an outside source
    input  wire logic [N-1:0] ext_lvl,
    input  wire logic [N-1:0] ext_oe,
    // Resolved level
    output logic      [N-1:0] pin_lvl
);
    // Undriven pins float high through the board pull-up
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (dut_oe[i] && ext_oe[i])
                pin_lvl[i] = 1'bx;
            else if (dut_oe[i])
                pin_lvl[i] = dut_out[i];
            else if (ext_oe[i])
                pin_lvl[i] = ext_lvl[i];
            else
                pin_lvl[i] = 1'b1;
        end
    end
endmodule // tcel_pin_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the timer channel mode block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        ref_clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        counter_ovf;
    logic        err;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [5:0]  match;
    logic [5:0]  pin_in;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic [5:0]  port_out;
    logic [5:0]  port_oe;
    logic [5:0]  ext_lvl;
    logic [5:0]  ext_oe;
    logic [5:0]  stb;
    int          n_fail;
    int          compares;
    int          n_stb;
    int          cyc;

    tcel_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_ovf(counter_ovf),
        .compare_match(match), .timer_channel_pin_in(pin_in),
        .timer_channel_pin_out(pin_out), .timer_channel_pin_oe(pin_oe),
        .port_pin_out(port_out), .port_pin_oe(port_oe),
        .capture_stb(stb));

    tcel_pin_model #(.N(6)) pins (.dut_out(pin_out), .dut_oe(pin_oe),
        .ext_lvl(ext_lvl), .ext_oe(ext_oe), .pin_lvl(pin_in));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (stb[0] === 1'b1)
            n_stb++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(logic o, logic m);
        @(posedge ref_clk);
        counter_ovf <= o;
        match       <= {5'h00, m};
        @(posedge ref_clk);
        counter_ovf <= 1'b0;
        match       <= 6'h00;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic drive_pin(logic lv);
        @(posedge ref_clk);
        ext_lvl[0] <= lv;
        repeat (4) @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int n = 0; n < 6; n++) begin
            apb(1'b0, 8'(4 * n), 32'h0000_0000);
            check("ctrl after reset", rd, 32'h0000_0000);
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("status after reset", rd & 32'h003F_003F, 32'h0000_0000);
        #1;
        check("pin out to port", {26'h0, pin_out}, {26'h0, port_out});
        check("pin oe to port", {26'h0, pin_oe}, {26'h0, port_oe});
    endtask

    task automatic t_unmapped();
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
    endtask

    task automatic t_capture();
        int r;
        ext_oe[0] <= 1'b1;
        for (int code = 1; code < 4; code++) begin
            // Overflow toggle set on purpose: capture must not react
            apb(1'b1, 8'h00, 32'h0000_0004 | 32'(code));
            drive_pin(1'b0);
            n_stb = 0;
            drive_pin(1'b1);
            r = n_stb;
            drive_pin(1'b0);
            check("rise capture", r, code & 1);
            check("fall capture", n_stb - r, code >> 1);
            pulse(1'b1, 1'b1);
            check("capture oe", {31'h0, pin_oe[0]}, 32'h0000_0000);
            check("no stray capture", n_stb - r, code >> 1);
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("flag set", rd & 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, 8'h18, 32'h0000_0001);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("flag cleared", rd & 32'h0000_0001, 32'h0000_0000);
        ext_oe[0] <= 1'b0;
    endtask

    task automatic t_compare();
        // Event code: bit1 overflow, bit0 compare match
        logic [4:0] ctl[13] = '{5'h08, 5'h09, 5'h00, 5'h09, 5'h0A, 5'h0B,
            5'h09, 5'h09, 5'h0D, 5'h0E, 5'h0A, 5'h12, 5'h13};
        logic [1:0] ev[13] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 2, 1, 1};
        logic       ex[13] = '{1, 0, 1, 1, 0, 1, 0, 1, 0, 1, 1, 0, 1};
        logic       oe;
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, 8'h00, {27'h0, ctl[i]});
            pulse(ev[i][1], ev[i][0]);
            oe = (ctl[i][1:0] != 2'b00) ? 1'b1 : port_oe[0];
            check("compare pin", {31'h0, pin_out[0]}, {31'h0, ex[i]});
            check("compare oe", {31'h0, pin_oe[0]}, {31'h0, oe});
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("pin owned", rd & 32'h0001_0000, 32'h0001_0000);
        // Clear in compare mode, where no edge can re-arm the flag
        apb(1'b1, 8'h18, 32'h0000_0001);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("oc flag cleared", rd & 32'h0000_0001, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        reset_n     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        counter_ovf = 1'b0;
        match       = 6'h00;
        port_out    = 6'h15;
        port_oe     = 6'h2A;
        ext_lvl     = 6'h00;
        ext_oe      = 6'h00;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_unmapped();
        t_capture();
        t_compare();
        // Second reset in mid-run must restore port control
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        complete_run();
    end
endmodule // tb
`default_nettype wire
